// >>> drd_seq.sv
// reset and diagnostics sequencer with apb task-file registers
//
// Operation
// - drive 1 on soft reset sets busy and releases pdiag within 1 ms
// - drive 0 on soft reset sets busy and peer status image to 80h
// - after busy, assert dasp, wait for reset bit clear, then run reset init
// - after reset clears load sector count 01h, other task registers 00h
// - drive 1 good reset: error 01h, status 50h, assert pdiag within 5 s
// - drive 1 bad reset: own code in error, status 50h, pdiag released
// - drive 0 good reset with peer: watch pdiag 6 s, error 01h, status 50h
// - drive 0 bad reset with peer: watch pdiag 31 s, own code, status 50h
// - drive 1 on diagnostics sets busy and releases pdiag within 1 ms
// - drive 0 diagnostics with peer: busy, peer status image 00h
// - drive 0 diagnostics without peer: busy in own and peer status image
// - diagnostics: assert dasp, run self test, then load task defaults
// - drive 1 diagnostics pass: error 01h, status 50h, pdiag within 5 s
// - drive 1 diagnostics fail: own code, status 50h, pdiag not asserted
// - drive 0 pass with peer: watch pdiag 6 s, status 50h, interrupt
// - drive 0 fail with peer: watch pdiag 6 s, own code, 50h, interrupt
// - drive 0 without peer: code, peer image 00h, status 50h, interrupt
// - peer never asserts pdiag: drive 0 sets error bit 7
// - busy set within 400 ns of seeing the reset bit set
// - drive 0 learns peer presence from dasp at power on
`timescale 1ns/100ps
`include "drd_defines.svh"
module drd_seq
   import drd_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = `DRD_CLK_HZ / `DRD_MS_PER_S
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic strapDrive1,
   input wire logic pdiagIn,
   output logic pdiagOut,
   output logic pdiagOe,
   input wire logic daspIn,
   output logic daspOut,
   output logic daspOe,
   output logic initStart,
   output logic initDiag,
   input wire logic initDone,
   input wire logic initPass,
   input wire logic [7:0] initCode,
   output logic intrq
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam logic [15:0] PRES_MS = 16'(`DRD_T_PRES_MS);
   localparam logic [15:0] D1_MS = 16'(`DRD_T_D1_S * `DRD_MS_PER_S);
   localparam logic [15:0] PASS_MS = 16'(`DRD_T_PASS_S * `DRD_MS_PER_S);
   localparam logic [15:0] FAIL_MS = 16'(`DRD_T_FAIL_S * `DRD_MS_PER_S);

   drd_state_t state;
   drd_tmr_if tmrIf ();
   logic [7:0] errReg;
   logic [7:0] statOwn;
   logic [7:0] statPeer;
   logic [7:0] tfReg [`DRD_TF_CNT];
   logic [7:0] diagCode;
   logic srst;
   logic srstPrev;
   logic isDrive1;
   logic strapped;
   logic peerPresent;
   logic runDiag;
   logic ldDef;
   logic irqSet;
   logic [31:0] next_rdata;
   logic next_err;
   logic wrEn;
   logic rdEn;
   logic srstRise;
   logic cmdDiag;
   logic tmo;
   logic runPass;
   logic [7:0] runCode;

   // ----------------------------------------
   // timer
   // ----------------------------------------
   drd_timer #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_timer (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .tmr(tmrIf)
   );

   assign tmo = tmrIf.expired && !tmrIf.start;
   assign srstRise = srst && !srstPrev;
   assign runPass = initDone && initPass;
   assign runCode = runPass ? `DRD_ERR_OK : (initDone ? initCode : `DRD_CODE_TMO);

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   assign wrEn = psel && penable && pready && pwrite;
   assign rdEn = psel && penable && pready && !pwrite;
   assign cmdDiag = wrEn && paddr == `DRD_OFF_CMD && pwdata[7:0] == `DRD_CMD_DIAG
      && state == ST_IDLE;

   always_comb begin
      next_rdata = 32'h0;
      next_err = 1'b0;
      case (paddr)
         `DRD_OFF_ERR: next_rdata = {24'h0, errReg};
         `DRD_OFF_STOWN: next_rdata = {24'h0, statOwn};
         `DRD_OFF_STPEER: next_rdata = {24'h0, statPeer};
         `DRD_OFF_DEVCTL: next_rdata = {29'h0, srst, 2'h0};
         `DRD_OFF_CMD: next_rdata = 32'h0;
         `DRD_OFF_CFG: next_rdata = {29'h0, intrq, peerPresent, isDrive1};
         default: begin
            if (paddr >= `DRD_OFF_TF0 && paddr < `DRD_OFF_STOWN && paddr[1:0] == 2'h0) begin
               next_rdata = {24'h0, tfReg[3'(paddr[7:2] - 6'h1)]};
            end else begin
               next_err = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && next_err;
         if (psel && penable && !pready && (!pwrite || next_err)) begin
            prdata <= next_rdata;
         end
      end
   end

   // ----------------------------------------
   // device control
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         srst <= 1'b0;
         srstPrev <= 1'b0;
      end else begin
         srstPrev <= srst;
         if (wrEn && paddr == `DRD_OFF_DEVCTL) begin
            srst <= pwdata[`DRD_SRST_BIT];
         end
      end
   end

   // ----------------------------------------
   // task-file registers
   // ----------------------------------------
   for (genvar i = 0; i < `DRD_TF_CNT; i++) begin : g_tf
      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            tfReg[i] <= (i == 0) ? `DRD_TF_DEF0 : `DRD_TF_DEFN;
         end else if (ldDef) begin
            tfReg[i] <= (i == 0) ? `DRD_TF_DEF0 : `DRD_TF_DEFN;
         end else if (wrEn && state == ST_IDLE && paddr == `DRD_OFF_TF0 + 8'(4 * i)) begin
            tfReg[i] <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------
   // host interrupt
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         intrq <= 1'b0;
      end else if (irqSet) begin
         intrq <= 1'b1;
      end else if ((rdEn && paddr == `DRD_OFF_STOWN) || srstRise) begin
         intrq <= 1'b0;
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_PWRON;
         errReg <= `DRD_ERR_OK;
         statOwn <= `DRD_ST_BUSY;
         statPeer <= `DRD_ST_BUSY;
         diagCode <= `DRD_ERR_OK;
         isDrive1 <= 1'b0;
         strapped <= 1'b0;
         peerPresent <= 1'b0;
         runDiag <= 1'b0;
         ldDef <= 1'b0;
         irqSet <= 1'b0;
         initStart <= 1'b0;
         initDiag <= 1'b0;
         pdiagOut <= 1'b0;
         pdiagOe <= 1'b1;
         daspOut <= 1'b0;
         daspOe <= 1'b1;
         tmrIf.start <= 1'b0;
         tmrIf.limitMs <= PRES_MS;
      end else begin
         tmrIf.start <= 1'b0;
         initStart <= 1'b0;
         ldDef <= 1'b0;
         irqSet <= 1'b0;
         if (srstRise && state != ST_PWRON) begin
            statOwn <= `DRD_ST_BUSY;
            runDiag <= 1'b0;
            if (isDrive1) begin
               pdiagOe <= 1'b1;
            end else begin
               statPeer <= `DRD_ST_BUSY;
            end
            daspOe <= 1'b0;
            state <= ST_HOLD;
         end else begin
            case (state)
               ST_PWRON: begin
                  if (!strapped) begin
                     strapped <= 1'b1;
                     isDrive1 <= strapDrive1;
                     daspOe <= !strapDrive1;
                     tmrIf.limitMs <= PRES_MS;
                     tmrIf.start <= 1'b1;
                  end else begin
                     if (!isDrive1 && !daspIn) begin
                        peerPresent <= 1'b1;
                     end
                     if (tmo) begin
                        daspOe <= 1'b1;
                        pdiagOe <= !isDrive1;
                        statOwn <= `DRD_ST_READY;
                        statPeer <= `DRD_ST_CLEAR;
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_IDLE: begin
                  if (cmdDiag) begin
                     statOwn <= `DRD_ST_BUSY;
                     if (isDrive1) begin
                        pdiagOe <= 1'b1;
                     end else if (peerPresent) begin
                        statPeer <= `DRD_ST_CLEAR;
                     end else begin
                        statPeer <= `DRD_ST_BUSY;
                     end
                     daspOe <= 1'b0;
                     runDiag <= 1'b1;
                     initDiag <= 1'b1;
                     initStart <= 1'b1;
                     tmrIf.limitMs <= D1_MS;
                     tmrIf.start <= 1'b1;
                     state <= ST_RUN;
                  end
               end
               ST_HOLD: begin
                  if (!srst) begin
                     ldDef <= 1'b1;
                     initDiag <= 1'b0;
                     initStart <= 1'b1;
                     tmrIf.limitMs <= D1_MS;
                     tmrIf.start <= 1'b1;
                     state <= ST_RUN;
                  end
               end
               ST_RUN: begin
                  if (initDone || (isDrive1 && tmo)) begin
                     if (runDiag) begin
                        ldDef <= 1'b1;
                     end
                     diagCode <= runCode;
                     if (isDrive1) begin
                        errReg <= runCode;
                        statOwn <= `DRD_ST_READY;
                        pdiagOe <= !runPass;
                        daspOe <= 1'b1;
                        state <= ST_IDLE;
                     end else if (peerPresent) begin
                        tmrIf.limitMs <= (!runDiag && !runPass) ? FAIL_MS : PASS_MS;
                        tmrIf.start <= 1'b1;
                        state <= ST_PDWAIT;
                     end else begin
                        errReg <= runCode;
                        if (runDiag) begin
                           statPeer <= `DRD_ST_CLEAR;
                           irqSet <= 1'b1;
                        end
                        statOwn <= `DRD_ST_READY;
                        daspOe <= 1'b1;
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_PDWAIT: begin
                  if (!pdiagIn || tmo) begin
                     if (!pdiagIn) begin
                        errReg <= diagCode;
                     end else begin
                        errReg <= diagCode | (8'h1 << `DRD_ERR_PEER_BIT);
                     end
                     statOwn <= `DRD_ST_READY;
                     irqSet <= runDiag;
                     daspOe <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// >>> drd_defines.svh
// constants for the reset and diagnostics sequencer
`ifndef DRD_DEFINES_SVH
`define DRD_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DRD_OFF_ERR 8'h00
`define DRD_OFF_TF0 8'h04
`define DRD_OFF_STOWN 8'h18
`define DRD_OFF_STPEER 8'h1c
`define DRD_OFF_DEVCTL 8'h20
`define DRD_OFF_CMD 8'h24
`define DRD_OFF_CFG 8'h28
// ----------------------------------------
// fields and values
// ----------------------------------------
`define DRD_SRST_BIT 2
`define DRD_CMD_DIAG 8'h90
`define DRD_ST_BUSY 8'h80
`define DRD_ST_READY 8'h50
`define DRD_ST_CLEAR 8'h00
`define DRD_ERR_OK 8'h01
`define DRD_ERR_PEER_BIT 7
`define DRD_CODE_TMO 8'h02
`define DRD_TF_CNT 5
`define DRD_TF_DEF0 8'h01
`define DRD_TF_DEFN 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define DRD_CLK_HZ 40000000
`define DRD_MS_PER_S 1000
`define DRD_T_PRES_MS 450
`define DRD_T_D1_S 5
`define DRD_T_PASS_S 6
`define DRD_T_FAIL_S 31
`endif

// >>> drd_pkg.sv
// types for the reset and diagnostics sequencer
package drd_pkg;
   typedef enum logic [4:0] {
      ST_PWRON = 5'b00001,
      ST_IDLE = 5'b00010,
      ST_HOLD = 5'b00100,
      ST_RUN = 5'b01000,
      ST_PDWAIT = 5'b10000
   } drd_state_t;
endpackage

// >>> drd_tmr_if.sv
// timer request and expiry between sequencer and timer
`timescale 1ns/100ps
interface drd_tmr_if;
   logic start;
   logic [15:0] limitMs;
   logic expired;
   modport ctl (output start, output limitMs, input expired);
   modport tmr (input start, input limitMs, output expired);
endinterface

// >>> drd_timer.sv
// millisecond timeout timer
`timescale 1ns/100ps
module drd_timer #(
   parameter int unsigned CYC_PER_MS = 40000
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   drd_tmr_if.tmr tmr
);
   logic [31:0] preCnt;
   logic [15:0] msCnt;
   logic run;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         preCnt <= 32'h0;
         msCnt <= 16'h0;
         run <= 1'b0;
         tmr.expired <= 1'b0;
      end else if (tmr.start) begin
         preCnt <= 32'h0;
         msCnt <= 16'h0;
         run <= 1'b1;
         tmr.expired <= 1'b0;
      end else if (run) begin
         if (preCnt == 32'(CYC_PER_MS - 1)) begin
            preCnt <= 32'h0;
            if (msCnt + 16'h1 >= tmr.limitMs) begin
               tmr.expired <= 1'b1;
               run <= 1'b0;
            end else begin
               msCnt <= msCnt + 16'h1;
            end
         end else begin
            preCnt <= preCnt + 32'h1;
         end
      end
   end
endmodule

// >>> drd_seq_asserts.sv
// port assertions for the reset and diagnostics sequencer
`timescale 1ns/100ps
`include "drd_defines.svh"
module drd_seq_asserts (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic strapDrive1,
   input wire logic pdiagOut,
   input wire logic pdiagOe,
   input wire logic daspOut,
   input wire logic daspOe,
   input wire logic initStart,
   input wire logic intrq
);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   ready_rise_a: assert property ($rose(psel && penable) |=> pready)
      else $error("pready missing in second access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   err_zero_a: assert property (pslverr |-> prdata == 32'h0)
      else $error("read data not zero on error");
   od_low_a: assert property (!pdiagOut && !daspOut)
      else $error("open-drain data not low");
   start_pulse_a: assert property (initStart |=> !initStart)
      else $error("init start longer than one cycle");
   start_dasp_a: assert property (initStart |-> !daspOe)
      else $error("dasp not asserted at init start");
   d1_release_a: assert property (strapDrive1 && initStart |-> pdiagOe)
      else $error("drive 1 pdiag not released while running");
   d0_nopdiag_a: assert property (!strapDrive1 |-> pdiagOe)
      else $error("drive 0 drives pdiag");
   irq_clear_a: assert property (pready && !pwrite && !pslverr
      && paddr == `DRD_OFF_STOWN |=> !intrq)
      else $error("status read did not clear intrq");
endmodule
bind drd_seq drd_seq_asserts chk (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .strapDrive1, .pdiagOut, .pdiagOe, .daspOut, .daspOe,
   .initStart, .intrq);

// >>> drd_peer_model.sv
// companion drive on the shared pdiag and dasp lines
`timescale 1ns/100ps
module drd_peer_model (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic actAsDrive1,
   input wire logic pdiagGo,
   output logic pdiagLow,
   output logic daspLow
);
   // ----------------------------------------
   // companion behaviour
   // ----------------------------------------
   logic [7:0] upCnt;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         upCnt <= 8'h00;
      end else if (upCnt != 8'hff) begin
         upCnt <= upCnt + 8'h01;
      end
   end
   // drive 1 announces itself on dasp early in the power-on window
   assign daspLow = actAsDrive1 && (upCnt < 8'h64);
   // drive 1 asserts pdiag only after passing; drive 0 never drives it
   assign pdiagLow = actAsDrive1 && pdiagGo;
endmodule

// >>> test_drive_reset_diag_sequencer.sv
// self-checking bench for the reset and diagnostics sequencer
`timescale 1ns/100ps
`include "drd_defines.svh"
module test_drive_reset_diag_sequencer;
   // ----------------------------------------
   // bench signals and instances
   // ----------------------------------------
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic strapDrive1 = 1'b0;
   logic initDone = 1'b0;
   logic initPass = 1'b0;
   logic [7:0] initCode = 8'h00;
   logic pdiagGo = 1'b0;
   logic peerD1 = 1'b1;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, pdiagOut, pdiagOe, daspOut, daspOe;
   logic initStart, initDiag, intrq, pdiagLow, daspLow;
   wire logic pdiagIn;
   wire logic daspIn;
   int nMismatch = 0;
   int nCompared = 0;
   int cyc = 0;
   // shared lines are pulled up; low when any party drives
   assign pdiagIn = (pdiagOe | pdiagOut) & !pdiagLow;
   assign daspIn = (daspOe | daspOut) & !daspLow;
   always #12.5 sys_clk = ~sys_clk;
   drd_seq #(.CYC_PER_MS(2)) uut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .strapDrive1, .pdiagIn, .pdiagOut, .pdiagOe,
      .daspIn, .daspOut, .daspOe, .initStart, .initDiag, .initDone, .initPass,
      .initCode, .intrq);
   drd_peer_model peer (.sys_clk, .arst_n, .actAsDrive1(peerD1), .pdiagGo, .pdiagLow,
      .daspLow);
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task results;
      $display("compared %0d mismatches %0d", nCompared, nMismatch);
      if (nMismatch == 0 && nCompared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         nMismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rdat, exp);
   endtask
   task doneInit(input logic pass, input logic [7:0] code);
      initPass <= pass;
      initCode <= code;
      initDone <= 1'b1;
      @(posedge sys_clk);
      initDone <= 1'b0;
   endtask
   task runInit(input logic pass, input logic [7:0] code, input logic diag);
      while (initStart !== 1'b1) @(posedge sys_clk);
      chk("diag", initDiag, {31'h0, diag});
      doneInit(pass, code);
   endtask
   task resetAs(input logic d1, input logic pres);
      arst_n <= 1'b0;
      strapDrive1 <= d1;
      peerD1 <= !d1 && pres;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (910) @(posedge sys_clk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task tPower;
      rdChk("cfg", `DRD_OFF_CFG, 32'h2);
      rdChk("stown", `DRD_OFF_STOWN, 32'h50);
      apb(1'b0, 8'h3c, 32'h0);
      chk("slverr", rerr, 32'h1);
   endtask
   task tSrst;
      apb(1'b1, `DRD_OFF_TF0, 32'h33);
      rdChk("count", `DRD_OFF_TF0, 32'h33);
      apb(1'b1, `DRD_OFF_DEVCTL, 32'h4);
      rdChk("stown", `DRD_OFF_STOWN, 32'h80);
      rdChk("stpeer", `DRD_OFF_STPEER, 32'h80);
      chk("dasp", daspOe, 32'h0);
      apb(1'b1, `DRD_OFF_DEVCTL, 32'h0);
      runInit(1'b1, 8'h00, 1'b0);
      pdiagGo <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rdChk("err", `DRD_OFF_ERR, 32'h01);
      rdChk("stown", `DRD_OFF_STOWN, 32'h50);
      for (int i = 0; i < 5; i++) begin
         rdChk("task", `DRD_OFF_TF0 + 8'(4 * i), (i == 0) ? 32'h1 : 32'h0);
      end
      pdiagGo <= 1'b0;
   endtask
   task tDiagPeerFail;
      apb(1'b1, `DRD_OFF_CMD, 32'h90);
      runInit(1'b1, 8'h00, 1'b1);
      rdChk("stpeer", `DRD_OFF_STPEER, 32'h0);
      while (intrq !== 1'b1) @(posedge sys_clk);
      rdChk("err", `DRD_OFF_ERR, 32'h81);
      rdChk("stown", `DRD_OFF_STOWN, 32'h50);
      @(posedge sys_clk);
      chk("intrq", intrq, 32'h0);
   endtask
   task tDiagSelfFail;
      apb(1'b1, `DRD_OFF_CMD, 32'h90);
      runInit(1'b0, 8'h05, 1'b1);
      pdiagGo <= 1'b1;
      while (intrq !== 1'b1) @(posedge sys_clk);
      rdChk("err", `DRD_OFF_ERR, 32'h05);
      rdChk("stown", `DRD_OFF_STOWN, 32'h50);
      pdiagGo <= 1'b0;
   endtask
   task tD1Diag;
      apb(1'b1, `DRD_OFF_CMD, 32'h90);
      @(posedge sys_clk);
      chk("pdiag", pdiagOe, 32'h1);
      runInit(1'b1, 8'h00, 1'b1);
      repeat (3) @(posedge sys_clk);
      rdChk("err", `DRD_OFF_ERR, 32'h01);
      rdChk("stown", `DRD_OFF_STOWN, 32'h50);
      chk("pdiag", pdiagOe, 32'h0);
   endtask
   task tD1Srst;
      apb(1'b1, `DRD_OFF_DEVCTL, 32'h4);
      repeat (3) @(posedge sys_clk);
      chk("pdiag", pdiagOe, 32'h1);
      rdChk("stown", `DRD_OFF_STOWN, 32'h80);
      apb(1'b1, `DRD_OFF_DEVCTL, 32'h0);
      runInit(1'b0, 8'h07, 1'b0);
      repeat (3) @(posedge sys_clk);
      rdChk("err", `DRD_OFF_ERR, 32'h07);
      rdChk("stown", `DRD_OFF_STOWN, 32'h50);
      chk("pdiag", pdiagOe, 32'h1);
   endtask
   task tSolo;
      rdChk("cfg", `DRD_OFF_CFG, 32'h0);
      apb(1'b1, `DRD_OFF_CMD, 32'h90);
      rdChk("stpeer", `DRD_OFF_STPEER, 32'h80);
      rdChk("stown", `DRD_OFF_STOWN, 32'h80);
      doneInit(1'b0, 8'h06);
      while (intrq !== 1'b1) @(posedge sys_clk);
      rdChk("err", `DRD_OFF_ERR, 32'h06);
      rdChk("stpeer", `DRD_OFF_STPEER, 32'h0);
      rdChk("stown", `DRD_OFF_STOWN, 32'h50);
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         nMismatch++;
         results;
      end
   end
   initial begin
      resetAs(1'b0, 1'b1);
      tPower;
      tSrst;
      tDiagPeerFail;
      tDiagSelfFail;
      resetAs(1'b1, 1'b1);
      tD1Diag;
      tD1Srst;
      resetAs(1'b0, 1'b0);
      tSolo;
      results;
   end
endmodule
